/* File: verilog/llc_map.svh */
// Frame identifiers, field positions, reset values and timing counts
`ifndef LLC_MAP_SVH
`define LLC_MAP_SVH
`define LLC_ID_CTRL_RD 8'h20
`define LLC_ID_CTRL_RSP 8'h50
`define LLC_ID_CTRL_WR 8'hA3
`define LLC_ID_COLOR_WR 8'h64
`define LLC_LEN_CTRL_RD 4'h2
`define LLC_LEN_CTRL_WR 4'h4
`define LLC_LEN_COLOR_WR 4'h8
`define LLC_READ_FILL 8'hFF
`define LLC_CTRL_RST 8'h01
`define LLC_BIT_CAL_EN 7
`define LLC_BIT_LIGHT 5
`define LLC_BIT_SINGLE 7
`define LLC_CAL_SHIFT 7
`define LLC_UPD_NOW 2'h0
`define LLC_UPD_STORE 2'h1
`define LLC_UPD_HELD 2'h2
`define LLC_RSP_TIMEOUT_NS 2000
`define LLC_RSP_TIMEOUT_CYC (`LLC_RSP_TIMEOUT_NS / 8)
`define LLC_REG_CMD 3'h0
`define LLC_REG_GROUP 3'h1
`define LLC_REG_PAY0 3'h2
`define LLC_REG_PAY1 3'h3
`define LLC_REG_STATUS 3'h4
`define LLC_CMD_GO 31
`define LLC_CMD_BROAD 6
`endif

/* File: verilog/llc_pkg.sv */
// Types shared by both ends of the LED control command link
`default_nettype none
package llc_pkg;
	typedef enum logic [1:0] {
		LLC_TX_IDLE = 2'b00,
		LLC_TX_D1 = 2'b01,
		LLC_TX_D2 = 2'b10,
		LLC_TX_CHK = 2'b11
	} llc_tx_t;
	typedef enum logic [1:0] {
		LLC_M_IDLE = 2'b00,
		LLC_M_SEND = 2'b01,
		LLC_M_WAIT = 2'b10
	} llc_mstate_t;
	typedef enum logic [1:0] {
		LLC_K_CTRL_RD = 2'b00,
		LLC_K_CTRL_WR = 2'b01,
		LLC_K_COLOR_WR = 2'b10
	} llc_kind_t;
	typedef struct packed {
		logic [7:0] sum;
	} llc_chk_t;
endpackage : llc_pkg
`default_nettype wire

/* File: verilog/llc_link_if.sv */
// Byte-level frame link between master and LED node
`timescale 1ns/1ns
`default_nettype none
interface llc_link_if;
	logic [7:0] mData;
	logic mValid;
	logic mStart;
	logic mEnd;
	logic [7:0] sData;
	logic sValid;
	logic sEnd;
	modport dev (input mData, input mValid, input mStart, input mEnd, output sData, output sValid, output sEnd);
	modport mst (output mData, output mValid, output mStart, output mEnd, input sData, input sValid, input sEnd);
endinterface : llc_link_if
`default_nettype wire

/* File: verilog/llc_checksum.sv */
// Classic checksum accumulator: carry-wrapped sum, inverted on output
`timescale 1ns/1ns
`default_nettype none
module llc_checksum (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] data,
	output logic [7:0] check
);
	llc_pkg::llc_chk_t s;
	llc_pkg::llc_chk_t next_s;
	logic [8:0] wide;

	// Clear then add in one cycle starts a fresh sum
	always_comb
	begin
		next_s = s;
		if (clear)
			next_s.sum = 8'h00;
		wide = {1'b0, next_s.sum} + {1'b0, data};
		if (add)
			next_s.sum = wide[7:0] + {7'h00, wide[8]};
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign check = ~s.sum;
endmodule : llc_checksum
`default_nettype wire

/* File: verilog/llc_device.sv */
// LED node end: decodes control and colour frames, answers control reads
`timescale 1ns/1ns
`default_nettype none
`include "llc_map.svh"

// Behaviour
// - master reads control with address and filler
// - reply carries address and control byte
// - classic checksum over data bytes only
// - write control takes data byte four
// - select bit low means group addressing
// - group match on programmed group identifier
// - single node match on node address
// - control settings apply at once
// - calibration off loads colours unchanged
// - calibration on passes colours through matrix
// - colour frame field layout
// - mode 00 applies, 11 discards
// - mode 01 stores in holding buffer
// - mode 10 applies held colours
module llc_device (
	input wire logic core_clk,
	input wire logic rst,
	llc_link_if.dev lnk,
	input wire logic [5:0] nodeAddress,
	input wire logic [3:0] programmed_group_identifier,
	input wire logic [71:0] calCoef,
	output logic calEnable,
	output logic modulation_frequency_select,
	output logic global_light_switch,
	output logic thermal_control,
	output logic channel_1_enable,
	output logic channel_2_enable,
	output logic channel_3_enable,
	output logic [23:0] modValue,
	output logic [5:0] fadeTime,
	output logic fadeEnable,
	output logic fadeSlope,
	output logic [3:0] intensity
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic rxActive;
		logic [3:0] cnt;
		logic [7:0] id;
		logic [7:0][7:0] buf_;
		logic [7:0] ctrl;
		logic [23:0] hold;
		logic [23:0] mods;
		logic [5:0] fadeTime;
		logic fadeOn;
		logic fadeSlope;
		logic [3:0] intensity;
		llc_pkg::llc_tx_t tx;
		logic [7:0] sData;
		logic sValid;
		logic sEnd;
	} llc_dev_t;

	llc_dev_t s;
	llc_dev_t next_s;
	logic [7:0] rxCheck;
	logic [7:0] txCheck;
	logic rxClear;
	logic rxAdd;
	logic txClear;
	logic txAdd;
	logic [7:0] txByte;

	// Weighted sum of the three inputs for one channel, saturated
	function automatic logic [7:0] calMix(input logic [71:0] k, input logic [23:0] c, input logic [1:0] row);
		logic [17:0] acc;
		acc = 18'h00000;
		// Widen first: an 8-bit product would lose its upper byte inside the concatenation
		for (int j = 0; j < 3; j++)
			acc = acc + {2'h0, 16'(k[(3 * row + j) * 8 +: 8]) * 16'(c[j * 8 +: 8])};
		acc = acc >> `LLC_CAL_SHIFT;
		calMix = (acc[17:8] != 10'h000) ? 8'hFF : acc[7:0];
	endfunction : calMix

	// Colour path into the modulation registers
	function automatic logic [23:0] toMod(input logic calOn, input logic [71:0] k, input logic [23:0] c);
		toMod = c;
		if (calOn)
			toMod = {calMix(k, c, 2'h2), calMix(k, c, 2'h1), calMix(k, c, 2'h0)};
	endfunction : toMod

	// ****************************************
	// Checksums for receive and reply
	// ****************************************
	llc_checksum rxSum (
		.core_clk(core_clk),
		.rst(rst),
		.clear(rxClear),
		.add(rxAdd),
		.data(lnk.mData),
		.check(rxCheck)
	);

	llc_checksum txSum (
		.core_clk(core_clk),
		.rst(rst),
		.clear(txClear),
		.add(txAdd),
		.data(txByte),
		.check(txCheck)
	);

	// ****************************************
	// Frame decode and execution
	// ****************************************
	always_comb
	begin
		logic hit;
		logic chkOk;
		logic [15:0] groups;
		logic [1:0] mode;
		logic [23:0] colours;
		hit = 1'b0;
		chkOk = 1'b0;
		groups = 16'h0000;
		mode = 2'h0;
		colours = 24'h000000;
		next_s = s;
		next_s.sValid = 1'b0;
		next_s.sEnd = 1'b0;
		rxClear = 1'b0;
		rxAdd = lnk.mValid && !lnk.mStart && !lnk.mEnd && s.rxActive;
		txClear = 1'b0;
		txAdd = 1'b0;
		txByte = 8'h00;

		if (lnk.mValid && lnk.mStart)
		begin
			next_s.rxActive = 1'b1;
			next_s.id = lnk.mData;
			next_s.cnt = 4'h0;
			rxClear = 1'b1;
		end
		else if (rxAdd)
		begin
			if (s.cnt < 4'h8)
				next_s.buf_[s.cnt[2:0]] = lnk.mData;
			if (s.cnt < 4'h9)
				next_s.cnt = s.cnt + 4'h1;
		end
		else if (lnk.mValid && lnk.mEnd && s.rxActive)
		begin
			next_s.rxActive = 1'b0;
			chkOk = (lnk.mData == rxCheck);
			groups = {s.buf_[2], s.buf_[1]};
			if (s.buf_[0][`LLC_BIT_SINGLE])
				hit = (s.buf_[0][5:0] == nodeAddress);
			else
				hit = groups[programmed_group_identifier];
			mode = s.buf_[3][7:6];
			// colours in data bytes six to eight
			colours = {s.buf_[7], s.buf_[6], s.buf_[5]};

			// request must carry marker bits and filler
			if (chkOk && s.id == `LLC_ID_CTRL_RD && s.cnt == `LLC_LEN_CTRL_RD
				&& s.buf_[0][7:6] == 2'b11 && s.buf_[0][5:0] == nodeAddress
				&& s.buf_[1] == `LLC_READ_FILL && s.tx == llc_pkg::LLC_TX_IDLE)
			begin
				next_s.tx = llc_pkg::LLC_TX_D1;
				next_s.sValid = 1'b1;
				next_s.sData = `LLC_ID_CTRL_RSP;
				txClear = 1'b1;
			end
			if (chkOk && hit && s.id == `LLC_ID_CTRL_WR && s.cnt == `LLC_LEN_CTRL_WR)
			begin
				next_s.ctrl = {s.buf_[3][7:1], 1'b1};
			end
			if (chkOk && hit && s.id == `LLC_ID_COLOR_WR && s.cnt == `LLC_LEN_COLOR_WR)
			begin
				case (mode)
					`LLC_UPD_NOW:
						next_s.mods = toMod(s.ctrl[`LLC_BIT_CAL_EN], calCoef, colours);
					`LLC_UPD_STORE:
						next_s.hold = colours;
					`LLC_UPD_HELD:
						next_s.mods = toMod(s.ctrl[`LLC_BIT_CAL_EN], calCoef, s.hold);
					default:
						next_s.mods = s.mods;
				endcase
				// fade and intensity only with an update
				if (mode == `LLC_UPD_NOW || mode == `LLC_UPD_HELD)
				begin
					next_s.fadeTime = s.buf_[3][5:0];
					next_s.fadeOn = s.buf_[4][7];
					next_s.fadeSlope = s.buf_[4][6];
					next_s.ctrl[`LLC_BIT_LIGHT] = s.buf_[4][5];
					next_s.intensity = s.buf_[4][3:0];
				end
			end
		end

		// Reply bytes leave one per cycle after the identifier
		case (s.tx)
			llc_pkg::LLC_TX_D1:
			begin
				txByte = {2'b11, nodeAddress};
				txAdd = 1'b1;
				next_s.sValid = 1'b1;
				next_s.sData = txByte;
				next_s.tx = llc_pkg::LLC_TX_D2;
			end
			llc_pkg::LLC_TX_D2:
			begin
				// control byte with bit zero set
				txByte = s.ctrl;
				txAdd = 1'b1;
				next_s.sValid = 1'b1;
				next_s.sData = txByte;
				next_s.tx = llc_pkg::LLC_TX_CHK;
			end
			llc_pkg::LLC_TX_CHK:
			begin
				next_s.sValid = 1'b1;
				next_s.sEnd = 1'b1;
				next_s.sData = txCheck;
				next_s.tx = llc_pkg::LLC_TX_IDLE;
			end
			default:
				next_s.tx = next_s.tx;
		endcase
	end

	// Single register stage for all state
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.ctrl <= `LLC_CTRL_RST;
		end
		else
			s <= next_s;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign lnk.sData = s.sData;
	assign lnk.sValid = s.sValid;
	assign lnk.sEnd = s.sEnd;
	assign calEnable = s.ctrl[7];
	assign modulation_frequency_select = s.ctrl[6];
	assign global_light_switch = s.ctrl[5];
	assign thermal_control = s.ctrl[4];
	assign channel_3_enable = s.ctrl[3];
	assign channel_2_enable = s.ctrl[2];
	assign channel_1_enable = s.ctrl[1];
	assign modValue = s.mods;
	assign fadeTime = s.fadeTime;
	assign fadeEnable = s.fadeOn;
	assign fadeSlope = s.fadeSlope;
	assign intensity = s.intensity;
endmodule : llc_device
`default_nettype wire

/* File: verilog/llc_master.sv */
// Bus master end: Wishbone-driven frame sender and control reader
`timescale 1ns/1ns
`default_nettype none
`include "llc_map.svh"
module llc_master (
	input wire logic core_clk,
	input wire logic rst,
	llc_link_if.mst lnk,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);
	typedef struct packed {
		llc_pkg::llc_mstate_t st;
		logic [31:0] cmd;
		logic [31:0] grp;
		logic [31:0] pay0;
		logic [31:0] pay1;
		logic [8:0][7:0] msg;
		logic [3:0] len;
		logic [3:0] idx;
		logic [1:0] rxIdx;
		logic [7:0] rxId;
		logic [7:0] rxD1;
		logic [7:0] rspCtrl;
		logic done;
		logic err;
		logic [15:0] timer;
		logic [7:0] mData;
		logic mValid;
		logic mStart;
		logic mEnd;
		logic [31:0] dat;
		logic ack;
	} llc_mst_t;

	llc_mst_t s;
	llc_mst_t next_s;
	logic [7:0] txCheck;
	logic [7:0] rxCheck;
	logic txClear;
	logic txAdd;
	logic rxAdd;

	llc_checksum txSum (
		.core_clk(core_clk),
		.rst(rst),
		.clear(txClear),
		.add(txAdd),
		.data(next_s.mData),
		.check(txCheck)
	);

	llc_checksum rxSum (
		.core_clk(core_clk),
		.rst(rst),
		.clear(txClear),
		.add(rxAdd),
		.data(lnk.sData),
		.check(rxCheck)
	);

	// ****************************************
	// Register access, framing and reply check
	// ****************************************
	always_comb
	begin
		logic [31:0] m;
		logic [7:0] d1;
		logic go;
		m = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
		d1 = 8'h00;
		go = 1'b0;
		next_s = s;
		next_s.mValid = 1'b0;
		next_s.mStart = 1'b0;
		next_s.mEnd = 1'b0;
		next_s.mData = 8'h00;
		txClear = 1'b0;
		txAdd = 1'b0;
		rxAdd = 1'b0;
		// Answer one cycle after the request, drop the cycle after
		next_s.ack = cyc_i && stb_i && !s.ack;
		next_s.dat = 32'h00000000;
		if (cyc_i && stb_i && !s.ack)
		begin
			case (adr_i[4:2])
				`LLC_REG_CMD:
				begin
					next_s.dat = {1'b0, s.cmd[30:0]};
					if (we_i)
					begin
						next_s.cmd = (s.cmd & ~m) | (dat_i & m);
						go = dat_i[`LLC_CMD_GO] && sel_i[3] && s.st == llc_pkg::LLC_M_IDLE;
					end
				end
				`LLC_REG_GROUP:
				begin
					next_s.dat = s.grp;
					if (we_i)
						next_s.grp = (s.grp & ~m) | (dat_i & m);
				end
				`LLC_REG_PAY0:
				begin
					next_s.dat = s.pay0;
					if (we_i)
						next_s.pay0 = (s.pay0 & ~m) | (dat_i & m);
				end
				`LLC_REG_PAY1:
				begin
					next_s.dat = s.pay1;
					if (we_i)
						next_s.pay1 = (s.pay1 & ~m) | (dat_i & m);
				end
				`LLC_REG_STATUS:
					next_s.dat = {16'h0000, s.rspCtrl, 5'h00, s.err, s.done, s.st != llc_pkg::LLC_M_IDLE};
				default:
					next_s.dat = 32'h00000000;
			endcase
		end

		// Frame built from the registers at the moment of launch
		if (go)
		begin
			next_s.done = 1'b0;
			next_s.err = 1'b0;
			next_s.idx = 4'h0;
			next_s.rxIdx = 2'h0;
			next_s.st = llc_pkg::LLC_M_SEND;
			// select bit leads data byte one
			d1 = {next_s.cmd[`LLC_CMD_BROAD], 1'b1, next_s.cmd[5:0]};
			next_s.msg = {s.pay1[7:0], s.pay0, s.grp[15:8], s.grp[7:0], d1, `LLC_ID_CTRL_WR};
			next_s.len = `LLC_LEN_CTRL_WR;
			case (next_s.cmd[9:8])
				llc_pkg::LLC_K_CTRL_RD:
				begin
					next_s.msg[2:0] = {`LLC_READ_FILL, 2'b11, next_s.cmd[5:0], `LLC_ID_CTRL_RD};
					next_s.len = `LLC_LEN_CTRL_RD;
				end
				llc_pkg::LLC_K_COLOR_WR:
				begin
					next_s.msg[0] = `LLC_ID_COLOR_WR;
					next_s.len = `LLC_LEN_COLOR_WR;
				end
				default:
					next_s.msg[0] = `LLC_ID_CTRL_WR;
			endcase
		end

		case (s.st)
			llc_pkg::LLC_M_SEND:
			begin
				next_s.mValid = 1'b1;
				next_s.idx = s.idx + 4'h1;
				if (s.idx == 4'h0)
				begin
					next_s.mStart = 1'b1;
					next_s.mData = s.msg[0];
					txClear = 1'b1;
				end
				else if (s.idx <= s.len)
				begin
					next_s.mData = s.msg[s.idx];
					txAdd = 1'b1;
				end
				else
				begin
					next_s.mEnd = 1'b1;
					next_s.mData = txCheck;
					next_s.timer = 16'h0000;
					if (s.cmd[9:8] == llc_pkg::LLC_K_CTRL_RD)
						next_s.st = llc_pkg::LLC_M_WAIT;
					else
					begin
						next_s.st = llc_pkg::LLC_M_IDLE;
						next_s.done = 1'b1;
					end
				end
			end
			llc_pkg::LLC_M_WAIT:
			begin
				next_s.timer = s.timer + 16'h0001;
				rxAdd = lnk.sValid && !lnk.sEnd && s.rxIdx != 2'h0;
				if (lnk.sValid && !lnk.sEnd)
				begin
					next_s.rxIdx = s.rxIdx + 2'h1;
					case (s.rxIdx)
						2'h0:
							next_s.rxId = lnk.sData;
						2'h1:
							next_s.rxD1 = lnk.sData;
						default:
							next_s.rspCtrl = lnk.sData;
					endcase
				end
				if (lnk.sValid && lnk.sEnd)
				begin
					next_s.st = llc_pkg::LLC_M_IDLE;
					next_s.done = 1'b1;
					// Reply checked for identifier, address and sum
					next_s.err = !(lnk.sData == rxCheck && s.rxId == `LLC_ID_CTRL_RSP
						&& s.rxD1 == {2'b11, s.cmd[5:0]} && s.rxIdx == 2'h3);
				end
				else if (s.timer == 16'(`LLC_RSP_TIMEOUT_CYC))
				begin
					// Silent node must not hang the controller
					next_s.st = llc_pkg::LLC_M_IDLE;
					next_s.done = 1'b1;
					next_s.err = 1'b1;
				end
			end
			default:
				next_s.st = next_s.st;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign lnk.mData = s.mData;
	assign lnk.mValid = s.mValid;
	assign lnk.mStart = s.mStart;
	assign lnk.mEnd = s.mEnd;
	assign dat_o = s.dat;
	assign ack_o = s.ack;
endmodule : llc_master
`default_nettype wire

/* File: verif/llc_link_properties.sv */
// Concurrent checks on the LED control frame link between master and node
`timescale 1ns/1ns
`default_nettype none
`include "llc_map.svh"
module llc_link_properties (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] mData,
	input wire logic mValid,
	input wire logic mStart,
	input wire logic mEnd,
	input wire logic [7:0] sData,
	input wire logic sValid,
	input wire logic sEnd
);
	logic [7:0] mAcc;
	logic [7:0] sAcc;
	logic [7:0] lastId;
	logic sBusy;
	function automatic logic [7:0] addWrap(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = a + b;
		return s[7:0] + {7'h00, s[8]};
	endfunction : addWrap
	// Running sums over data bytes only, identifier kept aside
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			mAcc <= 8'h00;
			sAcc <= 8'h00;
			lastId <= 8'h00;
			sBusy <= 1'b0;
		end
		else
		begin
			if (mValid && mStart)
			begin
				mAcc <= 8'h00;
				lastId <= mData;
			end
			else if (mValid && !mEnd)
				mAcc <= addWrap(mAcc, mData);
			if (sValid && sEnd)
				sBusy <= 1'b0;
			else if (sValid && !sBusy)
			begin
				sBusy <= 1'b1;
				sAcc <= 8'h00;
			end
			else if (sValid)
				sAcc <= addWrap(sAcc, sData);
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	AST_MST_CHK: assert property (mValid && mEnd |-> mData == ~mAcc)
		else $error("request checksum wrong");
	AST_RSP_CHK: assert property (sValid && sEnd |-> sData == ~sAcc)
		else $error("reply checksum wrong");
	AST_RSP_ID: assert property ($rose(sValid) |-> sData == `LLC_ID_CTRL_RSP)
		else $error("reply identifier wrong");
	AST_RSP_SHAPE: assert property ($rose(sValid) |-> !sEnd ##1 (sValid && !sEnd && sData[7:6] == 2'b11)
		##1 (sValid && !sEnd && sData[0]) ##1 (sValid && sEnd) ##1 !sValid)
		else $error("reply layout wrong");
	AST_RSP_CAUSE: assert property ($rose(sValid) |-> $past(mEnd) && lastId == `LLC_ID_CTRL_RD)
		else $error("reply without read request");
	AST_WR_SILENT: assert property (mValid && mEnd && lastId != `LLC_ID_CTRL_RD |=> !sValid)
		else $error("reply to a write frame");
	AST_RD_FORM: assert property (mValid && mStart && mData == `LLC_ID_CTRL_RD |->
		##1 (mValid && mData[7:6] == 2'b11) ##1 (mValid && mData == `LLC_READ_FILL) ##1 (mValid && mEnd))
		else $error("read request layout wrong");
	AST_WR_LEN: assert property (mValid && mStart && mData == `LLC_ID_CTRL_WR |-> ##5 (mValid && mEnd))
		else $error("control frame length wrong");
	AST_COL_LEN: assert property (mValid && mStart && mData == `LLC_ID_COLOR_WR |-> ##9 (mValid && mEnd))
		else $error("colour frame length wrong");
	AST_STROBE: assert property (mStart || mEnd |-> mValid)
		else $error("frame marker without byte strobe");
	// Main traffic kinds seen at least once
	cover property ($rose(sValid));
	cover property (mValid && mStart && mData == `LLC_ID_CTRL_WR);
	cover property (mValid && mStart && mData == `LLC_ID_COLOR_WR);
endmodule : llc_link_properties
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench: Wishbone-driven master facing the LED node
`timescale 1ns/1ns
`default_nettype none
`include "llc_map.svh"
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin fails++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
	logic core_clk, rst, cyc, stb, we, ack;
	logic [4:0] adr;
	logic [3:0] sel;
	logic [31:0] datW, datR, st, q;
	logic [5:0] node = 6'h15;
	logic [3:0] grpId = 4'hA;
	// Row one halves, row two sums the first two, row three unity
	logic [71:0] calCoef = 72'h800000008080000040;
	logic calEn, freqSel, lightOn, thermal, ch1En, ch2En, ch3En, fadeEn, fadeSl, light2;
	logic [23:0] modValue;
	logic [5:0] fadeTime;
	logic [3:0] inten;
	logic [7:0] ctrlByte, chk2;
	logic [7:0] rsp[$];
	logic [7:0] fr[$];
	int fails = 0;
	int samplesChecked = 0;
	llc_link_if lnk();
	llc_link_if lnk2();
	llc_master i_llc_master (.core_clk(core_clk), .rst(rst), .lnk(lnk), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack));
	llc_device i_llc_device (.core_clk(core_clk), .rst(rst), .lnk(lnk), .nodeAddress(node),
		.programmed_group_identifier(grpId), .calCoef(calCoef), .calEnable(calEn),
		.modulation_frequency_select(freqSel), .global_light_switch(lightOn), .thermal_control(thermal),
		.channel_1_enable(ch1En), .channel_2_enable(ch2En), .channel_3_enable(ch3En), .modValue(modValue),
		.fadeTime(fadeTime), .fadeEnable(fadeEn), .fadeSlope(fadeSl), .intensity(inten));
	// Second node fed by hand so frames can be broken on purpose
	llc_device i_llc_device_2 (.core_clk(core_clk), .rst(rst), .lnk(lnk2), .nodeAddress(node),
		.programmed_group_identifier(grpId), .calCoef(calCoef), .calEnable(), .modulation_frequency_select(),
		.global_light_switch(light2), .thermal_control(), .channel_1_enable(), .channel_2_enable(),
		.channel_3_enable(), .modValue(), .fadeTime(), .fadeEnable(), .fadeSlope(), .intensity());
	llc_link_properties i_llc_link_properties (.core_clk(core_clk), .rst(rst), .mData(lnk.mData),
		.mValid(lnk.mValid), .mStart(lnk.mStart), .mEnd(lnk.mEnd), .sData(lnk.sData), .sValid(lnk.sValid),
		.sEnd(lnk.sEnd));
	assign ctrlByte = {calEn, freqSel, lightOn, thermal, ch3En, ch2En, ch1En, 1'b1};
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] chkOf(input logic [7:0] a[$]);
		logic [8:0] s;
		s = 9'h000;
		foreach (a[i])
		begin
			s = s + a[i];
			s = s[7:0] + s[8];
		end
		return ~s[7:0];
	endfunction : chkOf
	task automatic conclude();
		$display("checks %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	// One classic cycle, held until ack is sampled high
	task automatic wbXfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		datW <= d;
		@(posedge core_clk);
		// No cycle count assumed: only the watchdog ends a silent slave
		while (ack !== 1'b1)
			@(posedge core_clk);
		r = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wbXfer
	task automatic cmdRun(input logic [1:0] kind, input logic single, input logic [5:0] a,
		input logic [15:0] grp, input logic [31:0] p0, input logic [7:0] p1);
		int n;
		n = 0;
		rsp = {};
		wbXfer(1'b1, {`LLC_REG_GROUP, 2'b00}, {16'h0000, grp}, q);
		wbXfer(1'b1, {`LLC_REG_PAY0, 2'b00}, p0, q);
		wbXfer(1'b1, {`LLC_REG_PAY1, 2'b00}, {24'h000000, p1}, q);
		wbXfer(1'b1, {`LLC_REG_CMD, 2'b00}, {1'b1, 21'h000000, kind, 1'b0, single, a}, q);
		do
		begin
			wbXfer(1'b0, {`LLC_REG_STATUS, 2'b00}, 32'h00000000, st);
			n++;
		end
		while (st[0] !== 1'b0 && n < 400);
		// Poll limit running out counts as a failure
		if (st[0] !== 1'b0)
			fails++;
	endtask : cmdRun
	task automatic readCtrl(input logic [7:0] exp);
		cmdRun(2'h0, 1'b1, node, 16'h0000, 32'h00000000, 8'h00);
		`CHK("ctrl", exp, st[15:8])
		`CHK("rspId", `LLC_ID_CTRL_RSP, rsp[0])
		`CHK("rspAddr", {2'b11, node}, rsp[1])
		`CHK("rspChk", chkOf(rsp[1:2]), rsp[3])
	endtask : readCtrl
	task automatic colour(input logic [1:0] m, input logic [5:0] ft, input logic [7:0] b5, input logic [23:0] c);
		cmdRun(2'h2, 1'b1, node, 16'h0000, {c[15:8], c[7:0], b5, m, ft}, c[23:16]);
	endtask : colour
	task automatic outs(input logic [23:0] m, input logic [5:0] ft, input logic [7:0] b5);
		`CHK("modValue", m, modValue)
		`CHK("fadeTime", ft, fadeTime)
		`CHK("fadeBits", {b5[7:6], b5[3:0]}, {fadeEn, fadeSl, inten})
	endtask : outs
	task automatic sendRaw(input logic [7:0] f[$]);
		foreach (f[i])
		begin
			@(posedge core_clk);
			lnk2.mValid <= 1'b1;
			lnk2.mStart <= (i == 0);
			lnk2.mEnd <= (i == f.size() - 1);
			lnk2.mData <= f[i];
		end
		@(posedge core_clk);
		lnk2.mValid <= 1'b0;
		lnk2.mStart <= 1'b0;
		lnk2.mEnd <= 1'b0;
		lnk2.mData <= ~f[f.size() - 1];
		repeat (3) @(posedge core_clk);
	endtask : sendRaw
	// Capture every reply byte the node sends
	always @(posedge core_clk)
		if (lnk.sValid === 1'b1)
			rsp.push_back(lnk.sData);
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Hang guard, generous against the longest reply timeout
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		conclude();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		{rst, cyc, stb, we, adr, datW} = {1'b1, 40'h0};
		sel = 4'hF;
		{lnk2.mValid, lnk2.mStart, lnk2.mEnd, lnk2.mData} = 11'h000;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		`CHK("ctrlRst", `LLC_CTRL_RST, ctrlByte)
		readCtrl(8'h01);
		cmdRun(2'h1, 1'b1, node, 16'h0000, 32'h6B, 8'h00);
		`CHK("ctrlWr", 8'h6B, ctrlByte)
		readCtrl(8'h6B);
		cmdRun(2'h1, 1'b1, 6'h14, 16'hFFFF, 32'hFF, 8'h00);
		`CHK("ctrlMiss", 8'h6B, ctrlByte)
		cmdRun(2'h1, 1'b0, 6'h3F, 16'h0400, 32'h95, 8'h00);
		`CHK("ctrlGrp", 8'h95, ctrlByte)
		cmdRun(2'h1, 1'b0, node, 16'hFBFF, 32'h01, 8'h00);
		`CHK("ctrlGrpMiss", 8'h95, ctrlByte)
		colour(2'h0, 6'h2A, 8'hB9, 24'h21B060);
		outs(24'h21FF30, 6'h2A, 8'hB9);
		`CHK("lightCol", 8'hB5, ctrlByte)
		cmdRun(2'h1, 1'b1, node, 16'h0000, 32'h21, 8'h00);
		colour(2'h1, 6'h05, 8'h73, 24'h332211);
		outs(24'h21FF30, 6'h2A, 8'hB9);
		colour(2'h3, 6'h3F, 8'h73, 24'h665544);
		outs(24'h21FF30, 6'h2A, 8'hB9);
		colour(2'h2, 6'h11, 8'h73, 24'h998877);
		outs(24'h332211, 6'h11, 8'h73);
		cmdRun(2'h2, 1'b0, 6'h00, 16'h0400, 32'h5AA5B407, 8'hC3);
		outs(24'hC35AA5, 6'h07, 8'hB4);
		cmdRun(2'h0, 1'b1, 6'h2A, 16'h0000, 32'h00000000, 8'h00);
		`CHK("rdMissErr", 1'b1, st[2])
		`CHK("rdMissQuiet", 0, rsp.size())
		wbXfer(1'b1, 5'h18, 32'hFFFFFFFF, q);
		wbXfer(1'b0, 5'h18, 32'h00000000, q);
		`CHK("unmapped", 32'h00000000, q)
		fr = {`LLC_ID_CTRL_WR, 8'hD5, 8'h00, 8'h00, 8'h21};
		chk2 = chkOf(fr[1:$]);
		fr.push_back(chk2 ^ 8'h01);
		sendRaw(fr);
		`CHK("badChk", 1'b0, light2)
		fr[5] = chk2;
		sendRaw(fr);
		`CHK("goodChk", 1'b1, light2)
		conclude();
	end
endmodule : tb_top
`default_nettype wire
